// [verilog/ffs_defines.svh]
`ifndef FFS_DEFINES_SVH
`define FFS_DEFINES_SVH

// Register byte offsets and step table block numbers
`define FFS_CTRL_OFF 12'h000
`define FFS_DIR_OFF 12'h004
`define FFS_OSEL_OFF 12'h008
`define FFS_STAT_OFF 12'h00c
`define FFS_IST_OFF 12'h010
`define FFS_IMSK_OFF 12'h014
`define FFS_REM_OFF 12'h018
`define FFS_FREQ_BLK 7'h01
`define FFS_TIME_BLK 7'h02

// Control fields
`define FFS_CTRL_MODE_LSB 0
`define FFS_CTRL_START_LSB 4
`define FFS_CTRL_PAUSE_LSB 8
`define FFS_CTRL_STOPF_BIT 12
`define FFS_CTRL_RST 13'h0770
`define FFS_SEL_NONE 3'h7
`define FFS_NUM_DI 3'h6

// Output selector fields
`define FFS_OSEL_R1_LSB 0
`define FFS_OSEL_R2_LSB 8
`define FFS_OSEL_TR_LSB 16
`define FFS_OSEL_RST 5'h00

// Output function codes
`define FFS_FN_RUNNING 5'h10
`define FFS_FN_STEP_END 5'h11
`define FFS_FN_CYCLE_END 5'h12
`define FFS_FN_PAUSED 5'h13

// Interrupt bits
`define FFS_IRQ_STEP 0
`define FFS_IRQ_CYCLE 1
`define FFS_IRQ_ABORT 2
`define FFS_IRQ_PAUSE 3

// Timing
`define FFS_CLK_HZ 64'd50000000
`define FFS_TICK_MS 64'd1000
`define FFS_HOLD_MS 64'd100
`define FFS_TIME_MAX 16'h03e8

`endif

// [verilog/ffs_pkg.sv]
package ffs_pkg;

    typedef enum logic [2:0] {
        FFS_MODE_OFF = 3'b000,
        FFS_MODE_ONCE = 3'b001,
        FFS_MODE_LOOP = 3'b010,
        FFS_MODE_ONCE_STEP = 3'b011,
        FFS_MODE_LOOP_STEP = 3'b100
    } ffs_mode_t;

    typedef enum logic [1:0] {
        FFS_ST_IDLE = 2'b00,
        FFS_ST_RUN = 2'b01,
        FFS_ST_HALT = 2'b10,
        FFS_ST_DONE = 2'b11
    } ffs_state_t;

endpackage

// [verilog/ffs_sync.sv]
`timescale 1ns/1ps

module ffs_sync #(
    parameter int WIDTH = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

    // Three stages; a bit only moves once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (agree & s3_q) | (~agree & out_q);
        end
    end

    assign dout = out_q;

endmodule

// [verilog/ffs_sequencer.sv]
`timescale 1ns/1ps

`include "ffs_defines.svh"

module ffs_sequencer
    import ffs_pkg::*;
#(
    parameter int TICK_CYCLES = 32'((`FFS_TICK_MS * `FFS_CLK_HZ) / 64'd1000),
    parameter int HOLD_CYCLES = 32'((`FFS_HOLD_MS * `FFS_CLK_HZ) / 64'd1000),
    parameter int FREQ_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] digital_inputs,
    input wire logic drive_at_zero,
    output logic seq_active,
    output logic seq_run_cmd,
    output logic [FREQ_W-1:0] seq_freq_setpoint,
    output logic seq_reverse,
    output logic stop_function_select,
    output logic relay_output_one,
    output logic relay_output_two,
    output logic transistor_output,
    output logic irq
);

    // Software settings
    logic [12:0] ctrl_q;
    logic [7:0] direction_program_code_q;
    logic [4:0] r1fn_q;
    logic [4:0] r2fn_q;
    logic [4:0] trfn_q;
    logic [FREQ_W-1:0] step_frequency_setpoints_q [8];
    logic [9:0] step_run_times_q [8];
    logic [3:0] ist_q;
    logic [3:0] imsk_q;
    logic irq_q;
    logic [31:0] rd_q;

    // Sequencer state
    ffs_state_t state_q;
    ffs_state_t state_d;
    logic [2:0] step_q;
    logic [2:0] step_d;
    logic [9:0] remain_q;
    logic [9:0] remain_d;
    logic [31:0] tick_q;
    logic [31:0] tick_d;
    logic ev_step;
    logic ev_cycle;
    logic ev_abort;
    logic do_adv;
    logic paused_q;
    logic [31:0] shold_q;
    logic [31:0] chold_q;
    logic active_q;
    logic run_q;
    logic [FREQ_W-1:0] freq_q;
    logic rev_q;
    logic ro1_q;
    logic ro2_q;
    logic tr_q;

    // APB decode
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire setup = psel & ~penable;
    wire aligned = paddr[1:0] == 2'b00;
    wire [2:0] idx = paddr[4:2];
    wire hit_ctrl = paddr == `FFS_CTRL_OFF;
    wire hit_dir = paddr == `FFS_DIR_OFF;
    wire hit_osel = paddr == `FFS_OSEL_OFF;
    wire hit_stat = paddr == `FFS_STAT_OFF;
    wire hit_ist = paddr == `FFS_IST_OFF;
    wire hit_imsk = paddr == `FFS_IMSK_OFF;
    wire hit_rem = paddr == `FFS_REM_OFF;
    wire hit_frq = aligned & (paddr[11:5] == `FFS_FREQ_BLK);
    wire hit_tim = aligned & (paddr[11:5] == `FFS_TIME_BLK);
    wire mapped = hit_ctrl | hit_dir | hit_osel | hit_stat | hit_ist | hit_imsk
                | hit_rem | hit_frq | hit_tim;

    // Zero wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = rd_q;

    // Run times above the top of the range are clipped on write
    wire [9:0] time_wr = (pwdata[15:0] > `FFS_TIME_MAX) ?
                         10'(`FFS_TIME_MAX) : pwdata[9:0];

    // Mode decode, out-of-range codes act as disabled
    wire [2:0] mode = ctrl_q[`FFS_CTRL_MODE_LSB +: 3];
    wire mode_on = (mode != FFS_MODE_OFF) && (mode <= FFS_MODE_LOOP_STEP);
    wire stepped = (mode == FFS_MODE_ONCE_STEP) || (mode == FFS_MODE_LOOP_STEP);
    wire contin = (mode == FFS_MODE_LOOP) || (mode == FFS_MODE_LOOP_STEP);

    // Input assignment; an unassigned selector never asserts
    logic [5:0] di_s;
    wire [2:0] start_sel = ctrl_q[`FFS_CTRL_START_LSB +: 3];
    wire [2:0] pause_sel = ctrl_q[`FFS_CTRL_PAUSE_LSB +: 3];
    wire start_lvl = (start_sel < `FFS_NUM_DI) && di_s[start_sel];
    wire pause_lvl = (pause_sel < `FFS_NUM_DI) && di_s[pause_sel];
    wire go = start_lvl & mode_on;
    wire in_seq = (state_q == FFS_ST_RUN) || (state_q == FFS_ST_HALT);
    wire paused = pause_lvl & in_seq;
    wire tick_hit = tick_q == 32'(TICK_CYCLES - 1);

    ffs_sync #(
        .WIDTH(6)
    ) u_di_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(digital_inputs),
        .dout(di_s)
    );

    // Step takes part only with a nonzero run time
    logic [7:0] act;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_act
            assign act[gi] = step_run_times_q[gi] != 10'h000;
        end
    endgenerate

    // Lowest active step at or above a start index
    function automatic logic [3:0] find_from(input logic [7:0] m, input logic [3:0] f);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i] && (4'(i) >= f)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    wire [3:0] first = find_from(act, 4'h0);
    wire [3:0] nxt = find_from(act, {1'b0, step_q} + 4'h1);

    // Output function mapping for relays and transistor
    function automatic logic fn_val(input logic [4:0] code, input logic [3:0] lv);
        logic v;
        v = 1'b0;
        case (code)
            `FFS_FN_RUNNING: v = lv[0];
            `FFS_FN_STEP_END: v = lv[1];
            `FFS_FN_CYCLE_END: v = lv[2];
            `FFS_FN_PAUSED: v = lv[3];
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        remain_d = remain_q;
        tick_d = tick_q;
        ev_step = 1'b0;
        ev_cycle = 1'b0;
        ev_abort = 1'b0;
        do_adv = 1'b0;
        case (state_q)
            FFS_ST_IDLE: begin
                if (go && first[3]) begin
                    state_d = FFS_ST_RUN;
                    step_d = first[2:0];
                    remain_d = step_run_times_q[first[2:0]];
                    tick_d = 32'h0;
                end
            end
            FFS_ST_RUN: begin
                if (!go) begin
                    state_d = FFS_ST_IDLE;
                    ev_abort = 1'b1;
                end else if (!paused) begin
                    if (tick_hit) begin
                        tick_d = 32'h0;
                        if (remain_q <= 10'h001) begin
                            ev_step = 1'b1;
                            if (stepped) begin
                                state_d = FFS_ST_HALT;
                            end else begin
                                do_adv = 1'b1;
                            end
                        end else begin
                            remain_d = remain_q - 10'h001;
                        end
                    end else begin
                        tick_d = tick_q + 32'h1;
                    end
                end
            end
            FFS_ST_HALT: begin
                if (!go) begin
                    state_d = FFS_ST_IDLE;
                    ev_abort = 1'b1;
                end else if (!paused && drive_at_zero) begin
                    do_adv = 1'b1;
                end
            end
            FFS_ST_DONE: begin
                // Held start must not relaunch a finished single cycle
                if (!start_lvl) begin
                    state_d = FFS_ST_IDLE;
                end
            end
            default: begin
                state_d = FFS_ST_IDLE;
            end
        endcase
        // Advance to the next active step or close the cycle
        if (do_adv) begin
            tick_d = 32'h0;
            if (nxt[3]) begin
                state_d = FFS_ST_RUN;
                step_d = nxt[2:0];
                remain_d = step_run_times_q[nxt[2:0]];
            end else begin
                ev_cycle = 1'b1;
                if (contin && first[3]) begin
                    state_d = FFS_ST_RUN;
                    step_d = first[2:0];
                    remain_d = step_run_times_q[first[2:0]];
                end else begin
                    state_d = FFS_ST_DONE;
                end
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= FFS_ST_IDLE;
            step_q <= 3'h0;
            remain_q <= 10'h000;
            tick_q <= 32'h0;
            paused_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            remain_q <= remain_d;
            tick_q <= tick_d;
            paused_q <= paused;
        end
    end

    // Event stretch so a relay can follow a one-cycle event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shold_q <= 32'h0;
            chold_q <= 32'h0;
        end else begin
            shold_q <= ev_step ? 32'(HOLD_CYCLES) :
                       (shold_q != 32'h0) ? shold_q - 32'h1 : 32'h0;
            chold_q <= ev_cycle ? 32'(HOLD_CYCLES) :
                       (chold_q != 32'h0) ? chold_q - 32'h1 : 32'h0;
        end
    end

    // Indications offered to the output selectors
    wire [3:0] lv = {paused, chold_q != 32'h0, shold_q != 32'h0, in_seq};

    // Drive-side and terminal outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
            run_q <= 1'b0;
            freq_q <= '0;
            rev_q <= 1'b0;
            ro1_q <= 1'b0;
            ro2_q <= 1'b0;
            tr_q <= 1'b0;
        end else begin
            active_q <= in_seq;
            run_q <= state_q == FFS_ST_RUN;
            freq_q <= (state_q == FFS_ST_RUN) ? step_frequency_setpoints_q[step_q] : '0;
            rev_q <= direction_program_code_q[step_q];
            ro1_q <= fn_val(r1fn_q, lv);
            ro2_q <= fn_val(r2fn_q, lv);
            tr_q <= fn_val(trfn_q, lv);
        end
    end

    assign seq_active = active_q;
    assign seq_run_cmd = run_q;
    assign seq_freq_setpoint = freq_q;
    assign seq_reverse = rev_q;
    assign stop_function_select = ctrl_q[`FFS_CTRL_STOPF_BIT];
    assign relay_output_one = ro1_q;
    assign relay_output_two = ro2_q;
    assign transistor_output = tr_q;
    assign irq = irq_q;

    // Interrupt sources; a fresh event wins over a same-cycle clear
    wire [3:0] iset = {paused & ~paused_q, ev_abort, ev_cycle, ev_step};
    wire [3:0] iclr = (wr && hit_ist) ? pwdata[3:0] : 4'h0;
    wire [3:0] ist_d = (ist_q & ~iclr) | iset;

    // Status word
    wire [31:0] stat_w = {22'h0, state_q, 1'b0, step_q, 1'b0,
                          state_q == FFS_ST_HALT, paused, in_seq};

    // Read selection
    wire [31:0] rd_d =
        hit_ctrl ? {19'h0, ctrl_q} :
        hit_dir ? {24'h0, direction_program_code_q} :
        hit_osel ? {11'h0, trfn_q, 3'h0, r2fn_q, 3'h0, r1fn_q} :
        hit_stat ? stat_w :
        hit_ist ? {28'h0, ist_q} :
        hit_imsk ? {28'h0, imsk_q} :
        hit_rem ? {22'h0, remain_q} :
        hit_frq ? 32'(step_frequency_setpoints_q[idx]) :
        hit_tim ? {22'h0, step_run_times_q[idx]} : 32'h0;

    // Register writes and read capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `FFS_CTRL_RST;
            direction_program_code_q <= 8'h00;
            r1fn_q <= `FFS_OSEL_RST;
            r2fn_q <= `FFS_OSEL_RST;
            trfn_q <= `FFS_OSEL_RST;
            ist_q <= 4'h0;
            imsk_q <= 4'h0;
            irq_q <= 1'b0;
            rd_q <= 32'h0;
        end else begin
            ist_q <= ist_d;
            irq_q <= |(ist_d & imsk_q);
            if (setup) begin
                rd_q <= rd_d;
            end
            if (wr && hit_ctrl) begin
                ctrl_q <= pwdata[12:0];
            end
            if (wr && hit_dir) begin
                direction_program_code_q <= pwdata[7:0];
            end
            if (wr && hit_osel) begin
                r1fn_q <= pwdata[`FFS_OSEL_R1_LSB +: 5];
                r2fn_q <= pwdata[`FFS_OSEL_R2_LSB +: 5];
                trfn_q <= pwdata[`FFS_OSEL_TR_LSB +: 5];
            end
            if (wr && hit_imsk) begin
                imsk_q <= pwdata[3:0];
            end
        end
    end

    // Step tables, kept apart to stay a plain memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                step_frequency_setpoints_q[i] <= '0;
                step_run_times_q[i] <= 10'h000;
            end
        end else begin
            if (wr && hit_frq) begin
                step_frequency_setpoints_q[idx] <= pwdata[FREQ_W-1:0];
            end
            if (wr && hit_tim) begin
                step_run_times_q[idx] <= time_wr;
            end
        end
    end

endmodule

// [dv/ffs_sequencer_props.sv]
`timescale 1ns/1ps

module ffs_seq_props
    import ffs_pkg::*;
#(
    parameter int TICK_CYCLES = 20,
    parameter int HOLD_CYCLES = 4,
    parameter int FREQ_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] digital_inputs,
    input wire logic drive_at_zero,
    input wire logic seq_active,
    input wire logic seq_run_cmd,
    input wire logic [FREQ_W-1:0] seq_freq_setpoint,
    input wire logic seq_reverse,
    input wire logic stop_function_select,
    input wire logic relay_output_one,
    input wire logic relay_output_two,
    input wire logic transistor_output,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Drive command and setpoint only while the sequence owns the drive
    a_cmd_needs_active: assert property (seq_run_cmd |-> seq_active)
        else $error("run command without active sequence");
    a_freq_needs_run: assert property (seq_freq_setpoint != '0 |-> seq_run_cmd)
        else $error("setpoint nonzero while stopped");
    a_start_with_cmd: assert property ($rose(seq_active) |-> seq_run_cmd)
        else $error("sequence active without run command");
    // Sync latency plus one state step fits well inside eight quiet cycles
    a_inputs_idle_stop: assert property ((digital_inputs == 6'h00) [*8] |-> !seq_active)
        else $error("sequence still active with all inputs low");
    // Next stepped setpoint only once the drive has reached zero
    a_restart_at_zero: assert property ($rose(seq_run_cmd) && $past(seq_active)
        |-> $past(drive_at_zero) || $past(drive_at_zero, 2))
        else $error("step restarted before drive reached zero");
    // Bus side: zero wait, error only in access, read data held between setups
    a_slverr_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    a_ready_high: assert property (pready)
        else $error("ready low");
    a_prdata_hold: assert property (!$past(psel) |-> $stable(prdata))
        else $error("read data changed without setup");

    c_start: cover property ($rose(seq_active));
    c_step_halt: cover property ($fell(seq_run_cmd) && seq_active);
    c_irq: cover property ($rose(irq));
endmodule

bind ffs_sequencer ffs_seq_props #(.TICK_CYCLES(TICK_CYCLES), .HOLD_CYCLES(HOLD_CYCLES),
    .FREQ_W(FREQ_W)) u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digital_inputs(digital_inputs), .drive_at_zero(drive_at_zero),
    .seq_active(seq_active), .seq_run_cmd(seq_run_cmd), .seq_freq_setpoint(seq_freq_setpoint),
    .seq_reverse(seq_reverse), .stop_function_select(stop_function_select),
    .relay_output_one(relay_output_one), .relay_output_two(relay_output_two),
    .transistor_output(transistor_output), .irq(irq));

// [dv/ffs_drive_model.sv]
`timescale 1ns/1ps

module ffs_drive_model #(
    parameter int RAMP = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic seq_run_cmd,
    output logic drive_at_zero
);
    logic [7:0] lvl_q;

    // Frequency ramps up and down, so zero is reached only after a delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= 8'h00;
        end else if (seq_run_cmd && lvl_q < 8'(RAMP)) begin
            lvl_q <= lvl_q + 8'h01;
        end else if (!seq_run_cmd && lvl_q != 8'h00) begin
            lvl_q <= lvl_q - 8'h01;
        end
    end

    assign drive_at_zero = (lvl_q == 8'h00);
endmodule

// [dv/tb_fixed_frequency_sequencer.sv]
`timescale 1ns/1ps

`include "ffs_defines.svh"

module tb_fixed_frequency_sequencer;
    import ffs_pkg::*;
    localparam int TICK = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, r0;
    logic pready, pslverr, err, drive_at_zero, seq_active, seq_run_cmd, seq_reverse;
    logic stop_function_select, relay_output_one, relay_output_two, transistor_output, irq;
    logic [5:0] digital_inputs = 6'h00;
    logic [15:0] seq_freq_setpoint;
    logic seen_tr = 1'b0, seen_f1 = 1'b0;
    int bad_count = 0;
    int n_compared = 0;
    int waited;

    ffs_sequencer #(.TICK_CYCLES(TICK), .HOLD_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .digital_inputs(digital_inputs),
        .drive_at_zero(drive_at_zero), .seq_active(seq_active), .seq_run_cmd(seq_run_cmd),
        .seq_freq_setpoint(seq_freq_setpoint), .seq_reverse(seq_reverse),
        .stop_function_select(stop_function_select), .relay_output_one(relay_output_one),
        .relay_output_two(relay_output_two), .transistor_output(transistor_output), .irq(irq));
    ffs_drive_model u_drive (.pclk(pclk), .presetn(presetn), .seq_run_cmd(seq_run_cmd),
        .drive_at_zero(drive_at_zero));

    always #10 pclk = ~pclk;

    // Short output pulses are caught here so a wait cannot miss them
    always @(negedge pclk) begin
        if (transistor_output === 1'b1) seen_tr = 1'b1;
        if (seq_freq_setpoint === 16'h0200) seen_f1 = 1'b1;
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Request held until pready is sampled high at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_freq(input logic [15:0] f);
        waited = 0;
        while (seq_freq_setpoint !== f && waited < 400) begin
            @(negedge pclk);
            waited++;
        end
        chk("setpoint reached", f, seq_freq_setpoint);
    endtask

    task wait_act(input logic v);
        waited = 0;
        while (seq_active !== v && waited < 100) begin
            @(negedge pclk);
            waited++;
        end
        chk("active level", v, seq_active);
    endtask

    task set_di(input logic [5:0] v);
        @(posedge pclk);
        digital_inputs <= v;
    endtask

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        $display("BAD watchdog expected end seen hang");
        end_sim();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `FFS_CTRL_OFF, 32'h0);
        chk("ctrl reset", 32'h00000770, rd);
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped error", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h04c, 32'h000007ff);
        apb(1'b0, 12'h04c, 32'h0);
        chk("time clip", 32'h000003e8, rd);
        apb(1'b1, 12'h04c, 32'h0);
        apb(1'b1, 12'h040, 32'h1);
        apb(1'b1, 12'h048, 32'h2);
        apb(1'b1, 12'h020, 32'h100);
        apb(1'b1, 12'h024, 32'h200);
        apb(1'b1, 12'h028, 32'h300);
        apb(1'b1, `FFS_DIR_OFF, 32'h04);
        apb(1'b1, `FFS_OSEL_OFF, 32'h00121110);
        apb(1'b1, `FFS_IMSK_OFF, 32'h7);
        $display("test registers done");
        // Single cycle, start level already present when enabled
        set_di(6'h01);
        apb(1'b1, `FFS_CTRL_OFF, 32'h101);
        wait_act(1'b1);
        chk("first step", 16'h0100, seq_freq_setpoint);
        chk("forward", 1'b0, seq_reverse);
        chk("running out", 1'b1, relay_output_one);
        wait_freq(16'h0300);
        chk("step time", 1'b1, waited >= TICK - 2 && waited <= TICK + 2);
        chk("reverse", 1'b1, seq_reverse);
        chk("step end pulse", 1'b1, relay_output_two);
        wait_act(1'b0);
        repeat (10) @(negedge pclk);
        chk("cycle end pulse", 1'b1, seen_tr);
        chk("running off", 1'b0, relay_output_one);
        chk("done idle", 1'b0, seq_active);
        chk("skipped step", 1'b0, seen_f1);
        chk("irq set", 1'b1, irq);
        apb(1'b0, `FFS_IST_OFF, 32'h0);
        chk("events", 32'h3, rd);
        apb(1'b1, `FFS_IST_OFF, 32'h3);
        apb(1'b0, `FFS_IST_OFF, 32'h0);
        chk("events cleared", 32'h0, rd);
        chk("irq clear", 1'b0, irq);
        set_di(6'h00);
        $display("test single cycle done");
        // Continuous cycling with pause, abort and restart
        apb(1'b1, `FFS_OSEL_OFF, 32'h00131110);
        apb(1'b1, `FFS_CTRL_OFF, 32'h102);
        set_di(6'h01);
        wait_freq(16'h0300);
        wait_freq(16'h0100);
        chk("running kept", 1'b1, relay_output_one);
        wait_freq(16'h0300);
        set_di(6'h03);
        repeat (8) @(negedge pclk);
        chk("paused out", 1'b1, transistor_output);
        apb(1'b0, `FFS_REM_OFF, 32'h0);
        r0 = rd;
        repeat (3 * TICK) @(negedge pclk);
        apb(1'b0, `FFS_REM_OFF, 32'h0);
        chk("frozen time", r0, rd);
        chk("same step", 16'h0300, seq_freq_setpoint);
        apb(1'b0, `FFS_STAT_OFF, 32'h0);
        chk("paused status", 32'h00000123, rd);
        set_di(6'h01);
        wait_freq(16'h0100);
        wait_freq(16'h0300);
        set_di(6'h00);
        wait_act(1'b0);
        chk("stop command", 1'b0, seq_run_cmd);
        apb(1'b0, `FFS_IST_OFF, 32'h0);
        chk("abort event", 32'hf, rd);
        apb(1'b1, `FFS_IST_OFF, 32'hf);
        set_di(6'h01);
        wait_act(1'b1);
        chk("restart step", 16'h0100, seq_freq_setpoint);
        set_di(6'h00);
        wait_act(1'b0);
        $display("test continuous done");
        // Stepped modes stop between steps; off codes never start
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, `FFS_CTRL_OFF, 32'h1100 | m);
            // The write lands on the edge the task returns at
            @(negedge pclk);
            chk("stop function", 1'b1, stop_function_select);
            set_di(6'h01);
            if (m == 3 || m == 4) begin
                wait_act(1'b1);
                wait_freq(16'h0000);
                chk("halt between", 1'b1, seq_active && !seq_run_cmd);
                wait_freq(16'h0300);
                if (m == 4) wait_freq(16'h0100);
            end else if (m == 0 || m > 4) begin
                repeat (10) @(negedge pclk);
                chk("mode off", 1'b0, seq_active);
            end
            set_di(6'h00);
            wait_act(1'b0);
        end
        $display("test stepped modes done");
        end_sim();
    end
endmodule
